//--- hdl/sep_pkg.sv
// constants and types for the serial port error status block
package sep_pkg;
  localparam logic [11:0] SERIAL_ERROR_STATUS_OFFSET = 12'h2EA;
  localparam logic [7:0] SERIAL_ERROR_STATUS_RESET = 8'h00;
  localparam int BIT_FRAMING = 7;
  localparam int BIT_OVERRUN = 6;
  localparam int BIT_PARITY = 5;
  localparam int BIT_OVERFLOW = 4;
  localparam int BIT_ILLEGAL = 3;
  localparam int BIT_NOT_READY = 2;
  localparam int BIT_BLOCK = 1;
  localparam int BIT_COMMAND = 0;
  localparam logic [7:0] MODULE_FLAGS = 8'h0F;
  localparam logic [7:0] HOST_FLAGS = 8'hF0;
  localparam logic [7:0] CODE_SUCCESS = 8'h01;
  localparam logic [7:0] CODE_NAK = 8'h8B;
  localparam logic [7:0] CODE_PORT_OPEN = 8'h96;
  localparam logic [7:0] CODE_CONC_OFF = 8'h97;
  localparam logic [7:0] CODE_BAD_BUFFER = 8'h98;
  localparam logic [7:0] CODE_NOT_ACTIVE = 8'h9A;
  localparam int OPT_CONCURRENT = 0;
  localparam int OPT_INPUT = 2;
  localparam int OPT_OUTPUT = 3;
  localparam logic [3:0] BAUD_300_MAX_CODE = 4'h8;
  localparam logic [1:0] WLEN_RESET = 2'h0;
  localparam logic [3:0] BAUD_RESET = 4'h0;
  localparam logic [2:0] MON_RESET = 3'h0;
  localparam int CLK_HZ = 50000000;
  localparam int PRN_TIMEOUT_MS = 4000;
  localparam int PRN_TIMEOUT_CYC = PRN_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 8;
  typedef enum logic [3:0] {
    CMD_OPEN = 4'h0,
    CMD_CLOSE = 4'h1,
    CMD_START = 4'h2,
    CMD_INPUT = 4'h3,
    CMD_OUTPUT = 4'h4,
    CMD_BLOCK = 4'h5,
    CMD_CONFIG = 4'h6,
    CMD_STATUS = 4'h7
  } sep_cmd_t;
  typedef enum logic [0:0] {
    PRN_IDLE = 1'b0,
    PRN_WAIT = 1'b1
  } sep_prn_state_t;
endpackage

//--- hdl/sep_error_status.sv
// serial port error status block with holding buffer and printer port
`timescale 1ns/1ns
// Notes on behaviour
// - framing flag bit 7 when stop position for the word length is not mark
// - framing flag raised on arrival, not when read from the buffer
// - eight-bit framing flag cleared by status and by closing concurrent mode
// - module flags cleared as each operation starts; set wins; framing kept unless closing concurrent mode or configuring while inactive
// - overrun flag bit 6 set when the next character after lost data is buffered
// - parity flag bit 5 only with checking enabled; status clears it
// - full buffer: overflow flag bit 4, oldest character replaced; status clears
// - short-word concurrent start with both directions or fast baud sets bit 3
// - illegal option always sets command error too; status clears it
// - monitored ready line off refuses start or block output, sets bit 2
// - refusals answer NAK; flags kept for next status; status clears bit 2
// - failed block transfer sets bit 1 and refuses the command
// - unknown or unperformable command sets command error bit 0
// - module flags visible to status only while concurrent mode inactive
// - concurrent start on a port opened without concurrent option gives 151
// - opening an already open port gives 150
// - start with inconsistent user buffer gives 152
// - input without active concurrent mode gives 154
// - printer fault low: printer commands get no answer at all
// - printer NAK for nonzero options or no acceptance within 4 seconds
// - checked line off returns error instead of performing the operation

module sep_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  input wire logic drop
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic full;
  logic push;
  logic pop;
  assign full = cnt_q == (AW+1)'(D);
  assign out_valid = cnt_q != '0;
  assign in_ready = !full;
  // a drop frees the slot the same cycle, so a full buffer still takes data
  assign pop = out_valid & (out_ready | drop);
  assign push = in_valid & (!full | pop);
  assign out_data = mem[rp_q];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module sep_error_status #(
  parameter int PRN_TIMEOUT = sep_pkg::PRN_TIMEOUT_CYC,
  parameter int DEPTH = sep_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [7:0] cmd_arg1,
  input wire logic [7:0] cmd_arg2,
  input wire logic cmd_buf_bad,
  input wire logic cmd_blk_bad,
  output logic rsp_valid_q,
  output logic [7:0] rsp_code_q,
  output logic [7:0] rsp_status_q,
  output logic [7:0] err_status_q,
  output logic conc_active_q,
  input wire logic rx_valid,
  input wire logic [9:0] rx_frame,
  input wire logic rx_lost,
  input wire logic par_en,
  input wire logic par_odd,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  input wire logic dsr_pin,
  input wire logic cts_pin,
  input wire logic crx_pin,
  input wire logic prn_fault_pin,
  input wire logic prn_ack_pin,
  input wire logic prn_req,
  input wire logic [7:0] prn_opt1,
  input wire logic [7:0] prn_opt2,
  output logic prn_rsp_valid_q,
  output logic [7:0] prn_rsp_code_q
);
  localparam int TW = $clog2(PRN_TIMEOUT + 1);
  localparam logic [TW-1:0] TO_LAST = TW'(PRN_TIMEOUT - 1);

  // pin synchronisers: three stages, a rise counts once stages two and three agree, a fall as soon as they differ
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic [4:0] s3_q;
  logic [4:0] pin_q;
  logic [4:0] pins;
  assign pins = {prn_ack_pin, prn_fault_pin, dsr_pin, cts_pin, crx_pin};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= (pin_q & ~(s2_q ^ s3_q)) | (s2_q & ~(s2_q ^ s3_q));
    end
  end
  logic [2:0] rdy_now;
  logic fault_ok;
  logic ack_now;
  assign rdy_now = pin_q[2:0];
  assign fault_ok = pin_q[3];
  assign ack_now = pin_q[4];

  // port state and configuration
  logic open_q;
  logic conc_en_q;
  logic both_q;
  logic [1:0] wlen_q;
  logic [3:0] baud_q;
  logic [2:0] mon_q;
  logic [7:0] stat_q;
  logic lost_q;

  // command decode
  wire is_open = cmd_code == sep_pkg::CMD_OPEN;
  wire is_close = cmd_code == sep_pkg::CMD_CLOSE;
  wire is_start = cmd_code == sep_pkg::CMD_START;
  wire is_input = cmd_code == sep_pkg::CMD_INPUT;
  wire is_output = cmd_code == sep_pkg::CMD_OUTPUT;
  wire is_block = cmd_code == sep_pkg::CMD_BLOCK;
  wire is_cfg = cmd_code == sep_pkg::CMD_CONFIG;
  wire is_status = cmd_code == sep_pkg::CMD_STATUS;
  wire unknown = cmd_code > sep_pkg::CMD_STATUS;
  wire rdy_fail = |(mon_q & ~rdy_now);
  wire short_w = wlen_q != sep_pkg::WLEN_RESET;
  wire baud_hi = baud_q > sep_pkg::BAUD_300_MAX_CODE;
  wire ill_cond = short_w & (both_q | baud_hi);
  wire start_ok = is_start & open_q & conc_en_q & !cmd_buf_bad;
  wire blk_try = is_block & !conc_active_q;
  wire set_ill = cmd_valid & start_ok & ill_cond;
  wire set_nrd = cmd_valid & ((start_ok & !ill_cond) | blk_try) & rdy_fail;
  wire set_blk = cmd_valid & blk_try & !rdy_fail & cmd_blk_bad;
  wire cmd_bad = unknown | (is_cfg & conc_active_q) | (is_block & conc_active_q);
  wire set_cmd = set_ill | (cmd_valid & cmd_bad);
  wire start_go = cmd_valid & start_ok & !ill_cond & !rdy_fail;
  wire close_conc = cmd_valid & is_close & conc_active_q;

  // response code, first failing check wins
  wire [7:0] code_start = !conc_en_q ? sep_pkg::CODE_CONC_OFF :
    cmd_buf_bad ? sep_pkg::CODE_BAD_BUFFER :
    (ill_cond | rdy_fail) ? sep_pkg::CODE_NAK : sep_pkg::CODE_SUCCESS;
  wire [7:0] code_blk = (conc_active_q | rdy_fail | cmd_blk_bad) ?
    sep_pkg::CODE_NAK : sep_pkg::CODE_SUCCESS;
  wire [7:0] rsp_code_d = is_open ? (open_q ? sep_pkg::CODE_PORT_OPEN :
    sep_pkg::CODE_SUCCESS) :
    (is_start & !open_q) ? sep_pkg::CODE_NAK :
    is_start ? code_start :
    is_input ? (conc_active_q ? sep_pkg::CODE_SUCCESS : sep_pkg::CODE_NOT_ACTIVE) :
    is_block ? code_blk :
    cmd_bad ? sep_pkg::CODE_NAK : sep_pkg::CODE_SUCCESS;

  // receive path: stop position is one past the last data bit
  wire [3:0] dbits = 4'h8 - {2'h0, wlen_q};
  wire stop_bad = !rx_frame[dbits + 4'h1];
  wire [7:0] dmask = 8'hFF >> wlen_q;
  wire [7:0] rx_data = rx_frame[8:1] & dmask;
  wire par_bad = par_en & ((^rx_data) ^ par_odd);
  logic fifo_ready;
  wire drop = rx_valid & !fifo_ready & !(rd_valid & rd_ready);

  sep_fifo #(
    .W(sep_pkg::FIFO_WIDTH),
    .D(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(rx_valid),
    .in_ready(fifo_ready),
    .in_data(rx_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data),
    .drop(drop)
  );

  // flag set and clear terms; a set in the same cycle beats any clear
  wire [7:0] vis = conc_active_q ? (sep_pkg::HOST_FLAGS & {!short_w, 7'h7F}) : 8'hFF;
  wire st_req = cmd_valid & is_status;
  wire op_start = cmd_valid & !is_status;
  wire [7:0] set_v = {rx_valid & stop_bad, rx_valid & (lost_q | rx_lost),
    rx_valid & par_bad, drop, set_ill, set_nrd, set_blk, set_cmd};
  wire [7:0] clr_v = (st_req ? vis : 8'h00) |
    (op_start ? sep_pkg::MODULE_FLAGS : 8'h00) |
    ((close_conc | (cmd_valid & is_cfg & !conc_active_q)) ? 8'h80 : 8'h00);
  wire [7:0] stat_d = (stat_q & ~clr_v) | set_v;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_q <= sep_pkg::SERIAL_ERROR_STATUS_RESET;
      lost_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_code_q <= 8'h00;
      rsp_status_q <= 8'h00;
    end else begin
      stat_q <= stat_d;
      // lost data waits for the next buffered character
      lost_q <= (lost_q | rx_lost) & !rx_valid;
      rsp_valid_q <= cmd_valid;
      if (cmd_valid) rsp_code_q <= rsp_code_d;
      if (st_req) rsp_status_q <= stat_q & vis;
    end
  end
  assign err_status_q = stat_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      open_q <= 1'b0;
      conc_en_q <= 1'b0;
      both_q <= 1'b0;
      conc_active_q <= 1'b0;
      wlen_q <= sep_pkg::WLEN_RESET;
      baud_q <= sep_pkg::BAUD_RESET;
      mon_q <= sep_pkg::MON_RESET;
    end else if (cmd_valid) begin
      if (is_open & !open_q) begin
        open_q <= 1'b1;
        conc_en_q <= cmd_arg1[sep_pkg::OPT_CONCURRENT];
        both_q <= cmd_arg1[sep_pkg::OPT_INPUT] & cmd_arg1[sep_pkg::OPT_OUTPUT];
      end
      if (is_close) begin
        open_q <= 1'b0;
        conc_active_q <= 1'b0;
      end
      if (start_go) conc_active_q <= 1'b1;
      if (is_cfg & !conc_active_q) begin
        baud_q <= cmd_arg1[3:0];
        wlen_q <= cmd_arg1[5:4];
        mon_q <= cmd_arg2[2:0];
      end
    end
  end

  // printer port
  sep_pkg::sep_prn_state_t prn_q;
  logic [TW-1:0] tmo_q;
  wire opt_bad = (prn_opt1 != 8'h00) | (prn_opt2 != 8'h00);
  wire tmo_end = tmo_q == TO_LAST;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prn_q <= sep_pkg::PRN_IDLE;
      tmo_q <= '0;
      prn_rsp_valid_q <= 1'b0;
      prn_rsp_code_q <= 8'h00;
    end else begin
      prn_rsp_valid_q <= 1'b0;
      unique case (prn_q)
        sep_pkg::PRN_IDLE: begin
          tmo_q <= '0;
          // silence with fault low lets the host time out
          if (prn_req & fault_ok) begin
            if (opt_bad) begin
              prn_rsp_valid_q <= 1'b1;
              prn_rsp_code_q <= sep_pkg::CODE_NAK;
            end else begin
              prn_q <= sep_pkg::PRN_WAIT;
            end
          end
        end
        sep_pkg::PRN_WAIT: begin
          tmo_q <= tmo_q + 1'b1;
          if (!fault_ok) begin
            prn_q <= sep_pkg::PRN_IDLE;
          end else if (ack_now | tmo_end) begin
            prn_q <= sep_pkg::PRN_IDLE;
            prn_rsp_valid_q <= 1'b1;
            prn_rsp_code_q <= ack_now ? sep_pkg::CODE_SUCCESS : sep_pkg::CODE_NAK;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  framing_set_a: assert property (rx_valid && stop_bad |=> stat_q[7])
    else $error("framing flag missed");
  overrun_set_a: assert property ($rose(stat_q[6]) |-> $past(rx_valid))
    else $error("overrun flag without a buffered character");
  parity_off_a: assert property ($rose(stat_q[5]) |-> $past(par_en))
    else $error("parity flag with checking off");
  overflow_set_a: assert property (drop |=> stat_q[4])
    else $error("overflow flag missed");
  illegal_cmd_a: assert property (stat_q[3] |-> stat_q[0])
    else $error("illegal option without command error");
  notready_nak_a: assert property (set_nrd |=> rsp_valid_q && rsp_code_q == 8'h8B && stat_q[2])
    else $error("not ready refusal wrong");
  status_clear_a: assert property (st_req && !conc_active_q |=> !stat_q[2] && !stat_q[3])
    else $error("status did not clear module flags");
  input_inactive_a: assert property (cmd_valid && is_input && !conc_active_q
    |=> rsp_code_q == 8'h9A)
    else $error("input without concurrent mode accepted");
  unknown_cmd_a: assert property (cmd_valid && unknown |=> stat_q[0] && rsp_code_q == 8'h8B)
    else $error("unknown command not flagged");
  hidden_flags_a: assert property (st_req && conc_active_q |=> rsp_status_q[3:0] == 4'h0)
    else $error("module flags visible in concurrent mode");
  printer_fault_a: assert property (!fault_ok |=> !prn_rsp_valid_q)
    else $error("printer answered with fault low");
  c_start_cov: cover property (start_go ##1 conc_active_q);
  c_overflow_cov: cover property (drop);
  c_prn_cov: cover property (prn_rsp_valid_q && prn_rsp_code_q == 8'h01);
endmodule

//--- tb/sep_host_model.sv
// host model driving the command port of the error status block
`timescale 1ns/1ns
module sep_host_model (
  input wire logic clk,
  output logic cmd_valid,
  output logic [3:0] cmd_code,
  output logic [7:0] cmd_arg1,
  output logic [7:0] cmd_arg2,
  output logic cmd_buf_bad,
  output logic cmd_blk_bad,
  input wire logic rsp_valid_q,
  input wire logic [7:0] rsp_code_q,
  input wire logic conc_active_q
);
  logic strict = 1'b1;
  logic opened = 1'b0;
  logic conc_opt = 1'b0;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 4'hF;
    cmd_arg1 = 8'h00;
    cmd_arg2 = 8'h00;
    cmd_buf_bad = 1'b0;
    cmd_blk_bad = 1'b0;
  end
  // one edge per command; answer is taken 1 ns after that edge
  task automatic send(input logic [3:0] c, input logic [7:0] a1, input logic [7:0] a2,
      input logic bb, input logic kb, output logic rv, output logic [7:0] rc);
    rv = 1'b0;
    rc = 8'h00;
    // a careful host never reopens, never starts without the option, stays on the active port
    if (strict && ((c == 4'h0 && opened) || (c == 4'h2 && !conc_opt) ||
        (conc_active_q && !(c inside {4'h1, 4'h3, 4'h4, 4'h7})))) return;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_arg1 <= a1;
    cmd_arg2 <= a2;
    cmd_buf_bad <= bb;
    cmd_blk_bad <= kb;
    @(posedge clk);
    // released lines carry garbage, not the old value
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
    cmd_arg1 <= ~a1;
    cmd_arg2 <= ~a2;
    cmd_buf_bad <= 1'b0;
    cmd_blk_bad <= 1'b0;
    #1;
    rv = rsp_valid_q;
    rc = rsp_code_q;
    if (c == 4'h0 && rc == sep_pkg::CODE_SUCCESS) begin
      opened = 1'b1;
      conc_opt = a1[0];
    end
    if (c == 4'h1) opened = 1'b0;
  endtask
endmodule

//--- tb/sep_error_status_tb.sv
// self-checking bench for the serial port error status block
`timescale 1ns/1ns
module sep_error_status_tb;
  localparam int TMO = 50;
  localparam logic [7:0] NAK = sep_pkg::CODE_NAK;
  localparam logic [7:0] OK = sep_pkg::CODE_SUCCESS;
  logic clk, rst, cmd_valid, cmd_buf_bad, cmd_blk_bad, rsp_valid_q, conc_active_q, rv;
  logic [3:0] cmd_code;
  logic [7:0] cmd_arg1, cmd_arg2, rsp_code_q, rsp_status_q, err_status_q, rd_data, rc, d;
  logic [7:0] prn_opt1, prn_opt2, prn_rsp_code_q;
  logic rx_valid, rx_lost, par_en, par_odd, rd_valid, rd_ready, prn_rsp_valid_q;
  logic dsr_pin, cts_pin, crx_pin, prn_fault_pin, prn_ack_pin, prn_req;
  logic [9:0] rx_frame;
  logic [7:0] q[$];
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  sep_error_status #(.PRN_TIMEOUT(TMO), .DEPTH(32)) DUT (.clk, .rst, .cmd_valid, .cmd_code,
    .cmd_arg1, .cmd_arg2, .cmd_buf_bad, .cmd_blk_bad, .rsp_valid_q, .rsp_code_q, .rsp_status_q,
    .err_status_q, .conc_active_q, .rx_valid, .rx_frame, .rx_lost, .par_en, .par_odd,
    .rd_valid, .rd_ready, .rd_data, .dsr_pin, .cts_pin, .crx_pin, .prn_fault_pin,
    .prn_ack_pin, .prn_req, .prn_opt1, .prn_opt2, .prn_rsp_valid_q, .prn_rsp_code_q);
  sep_host_model host (.clk, .cmd_valid, .cmd_code, .cmd_arg1, .cmd_arg2, .cmd_buf_bad,
    .cmd_blk_bad, .rsp_valid_q, .rsp_code_q, .conc_active_q);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // the whole run needs a few hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic cmd(input logic [3:0] c, input logic [7:0] a1, input logic [7:0] a2,
      input logic bb, input logic kb, input logic [7:0] e);
    host.send(c, a1, a2, bb, kb, rv, rc);
    chk1("rsp_valid", 1'b1, rv);
    chk8("rsp_code", e, rc);
  endtask
  task automatic rx(input logic [7:0] dd, input logic stop, input logic lost);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_lost <= lost;
    rx_frame <= {stop, dd, 1'b0};
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_lost <= 1'b0;
    rx_frame <= ~{stop, dd, 1'b0};
    #1;
  endtask
  task automatic pop(input logic [7:0] e, input logic check);
    if (check) chk8("rd_data", e, rd_data);
    @(posedge clk);
    rd_ready <= 1'b1;
    @(posedge clk);
    rd_ready <= 1'b0;
    #1;
  endtask
  task automatic prn(input logic [7:0] o1, input logic seen, input logic [7:0] e);
    int k;
    k = 0;
    @(posedge clk);
    prn_req <= 1'b1;
    prn_opt1 <= o1;
    @(posedge clk);
    prn_req <= 1'b0;
    #1;
    while (prn_rsp_valid_q !== 1'b1 && k < TMO + 10) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk1("prn_rsp_valid", seen, prn_rsp_valid_q);
    if (seen) chk8("prn_rsp_code", e, prn_rsp_code_q);
  endtask
  initial begin
    void'($urandom(74358));
    {rst, rx_valid, rx_lost, par_en, par_odd, rd_ready} = 6'b100000;
    {dsr_pin, cts_pin, crx_pin, prn_fault_pin, prn_ack_pin, prn_req} = 6'h00;
    {prn_opt1, prn_opt2, rx_frame} = 26'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk8("err_status", sep_pkg::SERIAL_ERROR_STATUS_RESET, err_status_q);
    for (int c = 8; c < 16; c++) begin
      cmd(4'(c), 8'h00, 8'h00, 1'b0, 1'b0, NAK);
      chk1("cmd_err", 1'b1, err_status_q[0]);
    end
    cmd(4'h7, 8'h00, 8'h00, 1'b0, 1'b0, OK);
    chk8("rsp_status", 8'h01, rsp_status_q);
    chk8("err_status", 8'h00, err_status_q);
    host.strict = 1'b0;
    cmd(4'h3, 8'h00, 8'h00, 1'b0, 1'b0, sep_pkg::CODE_NOT_ACTIVE);
    cmd(4'h0, 8'h0C, 8'h00, 1'b0, 1'b0, OK);
    cmd(4'h0, 8'h0C, 8'h00, 1'b0, 1'b0, sep_pkg::CODE_PORT_OPEN);
    cmd(4'h2, 8'h00, 8'h00, 1'b0, 1'b0, sep_pkg::CODE_CONC_OFF);
    cmd(4'h1, 8'h00, 8'h00, 1'b0, 1'b0, OK);
    cmd(4'h6, 8'h10, 8'h00, 1'b0, 1'b0, OK);
    cmd(4'h0, 8'h0D, 8'h00, 1'b0, 1'b0, OK);
    cmd(4'h2, 8'h00, 8'h00, 1'b0, 1'b0, NAK);
    chk8("err_status", 8'h09, err_status_q);
    cmd(4'h7, 8'h00, 8'h00, 1'b0, 1'b0, OK);
    chk8("rsp_status", 8'h09, rsp_status_q);
    chk8("err_status", 8'h00, err_status_q);
    cmd(4'h1, 8'h00, 8'h00, 1'b0, 1'b0, OK);
    cmd(4'h0, 8'h05, 8'h00, 1'b0, 1'b0, OK);
    cmd(4'h6, 8'h19, 8'h00, 1'b0, 1'b0, OK);
    cmd(4'h2, 8'h00, 8'h00, 1'b0, 1'b0, NAK);
    chk8("err_status", 8'h09, err_status_q);
    cmd(4'h6, 8'h18, 8'h00, 1'b0, 1'b0, OK);
    chk8("err_status", 8'h00, err_status_q);
    cmd(4'h2, 8'h00, 8'h00, 1'b1, 1'b0, sep_pkg::CODE_BAD_BUFFER);
    cmd(4'h2, 8'h00, 8'h00, 1'b0, 1'b0, OK);
    cmd(4'h1, 8'h00, 8'h00, 1'b0, 1'b0, OK);
    cmd(4'h6, 8'h00, 8'h04, 1'b0, 1'b0, OK);
    cmd(4'h0, 8'h0D, 8'h00, 1'b0, 1'b0, OK);
    cmd(4'h2, 8'h00, 8'h00, 1'b0, 1'b0, NAK);
    chk8("err_status", 8'h04, err_status_q);
    cmd(4'h7, 8'h00, 8'h00, 1'b0, 1'b0, OK);
    chk8("rsp_status", 8'h04, rsp_status_q);
    cmd(4'h5, 8'h00, 8'h00, 1'b0, 1'b0, NAK);
    chk8("err_status", 8'h04, err_status_q);
    @(posedge clk) dsr_pin <= 1'b1;
    repeat (5) @(posedge clk);
    // cts and crx stay off: unmonitored lines must not block
    cmd(4'h5, 8'h00, 8'h00, 1'b0, 1'b1, NAK);
    chk8("err_status", 8'h02, err_status_q);
    cmd(4'h5, 8'h00, 8'h00, 1'b0, 1'b0, OK);
    cmd(4'h2, 8'h00, 8'h00, 1'b0, 1'b0, OK);
    chk1("conc_active", 1'b1, conc_active_q);
    @(posedge clk) par_en <= 1'b1;
    rx(8'h01, 1'b1, 1'b0);
    chk1("parity_err", 1'b1, err_status_q[5]);
    rx(8'h03, 1'b1, 1'b1);
    chk1("overrun_err", 1'b1, err_status_q[6]);
    rx(8'h00, 1'b0, 1'b0);
    chk1("framing_err", 1'b1, err_status_q[7]);
    chk1("rd_valid", 1'b1, rd_valid);
    cmd(4'h5, 8'h00, 8'h00, 1'b0, 1'b0, NAK);
    cmd(4'h7, 8'h00, 8'h00, 1'b0, 1'b0, OK);
    chk8("rsp_status", 8'hE0, rsp_status_q);
    chk8("err_high", 8'h00, err_status_q & 8'hF0);
    @(posedge clk) par_en <= 1'b0;
    rx(8'h01, 1'b1, 1'b0);
    chk1("parity_err", 1'b0, err_status_q[5]);
    // odd parity sense: a set low bit balances, an all-zero byte does not
    @(posedge clk) {par_en, par_odd} <= 2'b11;
    rx(8'h01, 1'b1, 1'b0);
    chk1("parity_odd", 1'b0, err_status_q[5]);
    rx(8'h00, 1'b1, 1'b0);
    chk1("parity_odd", 1'b1, err_status_q[5]);
    @(posedge clk) {par_en, par_odd} <= 2'b00;
    repeat (8) if (rd_valid === 1'b1) pop(8'h00, 1'b0);
    for (int i = 0; i < 33; i++) begin
      d = 8'($urandom);
      rx(d, 1'b1, 1'b0);
      q.push_back(d);
      if (i == 31) chk1("overflow_err", 1'b0, err_status_q[4]);
    end
    chk1("overflow_err", 1'b1, err_status_q[4]);
    void'(q.pop_front());
    for (int i = 0; i < 32; i++) pop(q.pop_front(), 1'b1);
    chk1("rd_valid", 1'b0, rd_valid);
    rx(8'h00, 1'b0, 1'b0);
    cmd(4'h1, 8'h00, 8'h00, 1'b0, 1'b0, OK);
    chk1("conc_active", 1'b0, conc_active_q);
    chk1("framing_err", 1'b0, err_status_q[7]);
    prn(8'h00, 1'b0, 8'h00);
    @(posedge clk) prn_fault_pin <= 1'b1;
    repeat (5) @(posedge clk);
    prn(8'h01, 1'b1, NAK);
    prn(8'h00, 1'b1, NAK);
    @(posedge clk) prn_ack_pin <= 1'b1;
    repeat (5) @(posedge clk);
    prn(8'h00, 1'b1, OK);
    summarize();
  end
endmodule
